// ---- verilog/bus_seq_pkg.sv ----
// package for the bus-cycle sequencer: states, codes, addresses, layout
// assumes a single 100 MHz clock domain shared by every user
package bus_seq_pkg;
    localparam int          CLK_MHZ        = 100;
    localparam int          RESET_HOLD_CLK = 3;
    localparam int          AUTO_WAIT_A    = 3;
    localparam int          AUTO_WAIT_B    = 2;
    localparam logic [3:0]  ST_IDLE        = 4'h0;
    localparam logic [3:0]  ST_REFRESH     = 4'h1;
    localparam logic [3:0]  ST_NMI_ACK     = 4'h5;
    localparam logic [3:0]  ST_NVEC_ACK    = 4'h6;
    localparam logic [3:0]  ST_VEC_ACK     = 4'h7;
    localparam logic [3:0]  ST_SEG_ACK     = 4'h4;
    localparam logic [3:0]  ST_MEM_OPER    = 4'h8;
    localparam logic [3:0]  ST_STACK       = 4'h9;
    localparam logic [3:0]  ST_SUB_FETCH   = 4'hC;
    localparam logic [3:0]  ST_FIRST_FETCH = 4'hD;
    localparam logic [15:0] RST_FLG_ADDR   = 16'h0002;
    localparam logic [15:0] RST_SEG_ADDR   = 16'h0004;
    localparam logic [15:0] RST_OFS_ADDR   = 16'h0006;
    localparam logic [15:0] NPSA_ADDR      = 16'h0000;
    localparam logic [6:0]  SEG_C          = 7'h00;
    localparam logic [1:0]  PUSH_CNT       = 2'h3;
    localparam logic [1:0]  FETCH_CNT      = 2'h3;

    // one machine cycle's phase within the sequencer
    typedef enum logic [3:0] {
        PH_IDLE = 4'h0,
        PH_T1   = 4'h1,
        PH_T2   = 4'h2,
        PH_AW   = 4'h3,
        PH_IW   = 4'h4,
        PH_T3   = 4'h5,
        PH_T4   = 4'h6,
        PH_T5   = 4'h7,
        PH_GRNT = 4'h8,
        PH_RST  = 4'h9
    } phase_t;

    // what kind of machine cycle is running
    typedef enum logic [2:0] {
        CY_INIT  = 3'h0,
        CY_FETCH = 3'h1,
        CY_ACK   = 3'h2,
        CY_PUSH  = 3'h3,
        CY_NPS   = 3'h4,
        CY_REFR  = 3'h5
    } cycle_t;

    // bus-side control outputs; their drive enable is a separate port
    typedef struct packed {
        logic       addr_strobe_n;
        logic       data_strobe_n;
        logic       mem_req;
        logic [3:0] status;
        logic       byte_word;
        logic       read_write;
        logic       normal_sys;
        logic [6:0] segment;
    } bus_ctl_t;
endpackage

// ---- verilog/cpu_bus_cycle_sequencer.sv ----
// bus-cycle sequencer: reset fetch, acknowledge, status save, grant, stop
// assumes all inputs synchronous to sys_clk; far side resolves the bus
`timescale 1ns/1ps

module cpu_bus_cycle_sequencer
(
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  wait_n,
    input  wire logic                  stop_n,
    input  wire logic                  nmi_n,
    input  wire logic                  vectored_interrupt_in,
    input  wire logic                  nonvectored_interrupt_in,
    input  wire logic                  segment_trap_in,
    input  wire logic                  bus_request_in_n,
    input  wire logic                  resource_busy_n,
    input  wire logic                  resource_req,
    input  wire logic                  last_cycle,
    input  wire logic                  test_and_set_instruction,
    input  wire logic [15:0]           pc_value,
    input  wire logic [15:0]           flag_control_word,
    input  wire logic [15:0]           muxed_addr_data_in,
    output logic      [15:0]           muxed_addr_data_out,
    output logic                       muxed_addr_data_oe,
    output bus_seq_pkg::bus_ctl_t      bus_ctl,
    output logic                       bus_ctl_oe,
    output logic                       bus_grant_out_n,
    output logic                       resource_req_out_n,
    output logic                       refresh_enable,
    output logic      [15:0]           ack_identifier,
    output logic                       nmi_pending,
    output logic                       fetch_done
);
    bus_seq_pkg::phase_t   ph_r, ph_nxt;
    bus_seq_pkg::cycle_t   cy_r, cy_nxt;
    bus_seq_pkg::bus_ctl_t ctl_r, ctl_nxt;
    logic [1:0]  cnt_r, cnt_nxt;
    logic [1:0]  idx_r, idx_nxt;
    logic [1:0]  hold_r;
    logic        nmi_d_r;
    logic        nmi_lat_r;
    logic        grant_pend_r;
    logic        grant_r;
    logic        stop_r;
    logic        atom_r;
    logic        ad_oe_r;
    logic [15:0] ad_r, ad_nxt;
    logic [15:0] id_r;
    logic [3:0]  ack_code_r;
    logic        rr_n_r;
    logic        done_r;

    // trap request decode and priority
    wire trap_any   = ~segment_trap_in | ~nmi_lat_r
                    | ~nonvectored_interrupt_in | ~vectored_interrupt_in;
    wire [3:0] trap_code = ~segment_trap_in ? bus_seq_pkg::ST_SEG_ACK  :
                           ~nmi_lat_r       ? bus_seq_pkg::ST_NMI_ACK  :
                           ~nonvectored_interrupt_in ?
                                              bus_seq_pkg::ST_NVEC_ACK :
                                              bus_seq_pkg::ST_VEC_ACK;
    wire nmi_fall   = nmi_d_r & ~nmi_n;
    wire in_t1      = (ph_r == bus_seq_pkg::PH_T1);
    wire cyc_end    = (ph_r == bus_seq_pkg::PH_T5)
                    | (ph_r == bus_seq_pkg::PH_T3 && cy_r != bus_seq_pkg::CY_ACK
                       && cy_r != bus_seq_pkg::CY_REFR
                       && !(cy_r == bus_seq_pkg::CY_FETCH && stop_r));
    wire req_ok     = ~bus_request_in_n & ~atom_r & ~test_and_set_instruction;
    wire as_rise    = in_t1 && cy_r == bus_seq_pkg::CY_ACK;
    wire [15:0] push_word = (idx_r == 2'h0) ? pc_value :
                            (idx_r == 2'h1) ? flag_control_word : id_r;

    // next phase and cycle sequencing
    always_comb
    begin
        ph_nxt  = ph_r;
        cy_nxt  = cy_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        ad_nxt  = ad_r;
        unique case (ph_r)
            bus_seq_pkg::PH_RST:
                if (hold_r == 2'(bus_seq_pkg::RESET_HOLD_CLK - 1))
                begin
                    ph_nxt  = bus_seq_pkg::PH_T1;
                    cy_nxt  = bus_seq_pkg::CY_INIT;
                    idx_nxt = 2'h0;
                    ad_nxt  = bus_seq_pkg::RST_FLG_ADDR;
                end
            bus_seq_pkg::PH_IDLE:
                ph_nxt = bus_seq_pkg::PH_T1;
            bus_seq_pkg::PH_T1:
            begin
                ph_nxt  = bus_seq_pkg::PH_T2;
                cnt_nxt = 2'h0;
            end
            bus_seq_pkg::PH_T2:
                if (cy_r == bus_seq_pkg::CY_ACK)
                    ph_nxt = bus_seq_pkg::PH_AW;
                else if (!wait_n)
                    ph_nxt = bus_seq_pkg::PH_IW;
                else
                    ph_nxt = bus_seq_pkg::PH_T3;
            bus_seq_pkg::PH_AW:
            begin
                cnt_nxt = cnt_r + 2'h1;
                // low wait inserts a wait state
                if (idx_r == 2'h0
                    && cnt_r == 2'(bus_seq_pkg::AUTO_WAIT_A - 1) && !wait_n)
                    ph_nxt = bus_seq_pkg::PH_IW;
                // second group of two automatic waits
                else if (idx_r == 2'h0
                    && cnt_r == 2'(bus_seq_pkg::AUTO_WAIT_A - 1))
                begin
                    idx_nxt = 2'h1;
                    cnt_nxt = 2'h0;
                end
                // sample wait in last automatic wait
                else if (idx_r == 2'h1
                    && cnt_r == 2'(bus_seq_pkg::AUTO_WAIT_B - 1))
                    ph_nxt = wait_n ? bus_seq_pkg::PH_T3 : bus_seq_pkg::PH_IW;
            end
            bus_seq_pkg::PH_IW:
                if (wait_n && cy_r == bus_seq_pkg::CY_ACK && idx_r == 2'h0)
                begin
                    ph_nxt  = bus_seq_pkg::PH_AW;
                    idx_nxt = 2'h1;
                    cnt_nxt = 2'h0;
                end
                else if (wait_n)
                    ph_nxt = bus_seq_pkg::PH_T3;
            bus_seq_pkg::PH_T3:
                // acknowledge finishes through T4 and T5
                if (cy_r == bus_seq_pkg::CY_ACK)
                    ph_nxt = bus_seq_pkg::PH_T4;
                // stop low inserts a refresh after T3
                else if (cy_r == bus_seq_pkg::CY_FETCH && stop_r)
                    ph_nxt = bus_seq_pkg::PH_T1;
                else if (cy_r == bus_seq_pkg::CY_REFR && !stop_n)
                    ph_nxt = bus_seq_pkg::PH_T1;
                // two dummy states close the fetch
                else if (cy_r == bus_seq_pkg::CY_REFR)
                    ph_nxt = bus_seq_pkg::PH_T4;
                else
                    ph_nxt = bus_seq_pkg::PH_IDLE;
            bus_seq_pkg::PH_T4:
                ph_nxt = bus_seq_pkg::PH_T5;
            bus_seq_pkg::PH_T5:
                ph_nxt = bus_seq_pkg::PH_IDLE;
            bus_seq_pkg::PH_GRNT:
                if (bus_request_in_n)
                    ph_nxt = bus_seq_pkg::PH_IDLE;
            default:
                ph_nxt = bus_seq_pkg::PH_RST;
        endcase
        // cycle kind chosen at the end of each machine cycle
        if (cyc_end)
        begin
            unique case (cy_r)
                bus_seq_pkg::CY_INIT:
                    if (idx_r == 2'h2)
                        cy_nxt = bus_seq_pkg::CY_FETCH;
                    else
                    begin
                        idx_nxt = idx_r + 2'h1;
                        ad_nxt  = (idx_r == 2'h0) ? bus_seq_pkg::RST_SEG_ADDR
                                                  : bus_seq_pkg::RST_OFS_ADDR;
                    end
                // traps sampled at end of last cycle
                bus_seq_pkg::CY_FETCH, bus_seq_pkg::CY_REFR:
                    if (last_cycle && trap_any)
                    begin
                        cy_nxt  = bus_seq_pkg::CY_ACK;
                        idx_nxt = 2'h0;
                    end
                    else
                        cy_nxt = bus_seq_pkg::CY_FETCH;
                bus_seq_pkg::CY_ACK:
                begin
                    cy_nxt  = bus_seq_pkg::CY_PUSH;
                    idx_nxt = 2'h0;
                end
                bus_seq_pkg::CY_PUSH:
                    if (idx_r == bus_seq_pkg::PUSH_CNT - 2'h1)
                    begin
                        cy_nxt  = bus_seq_pkg::CY_NPS;
                        idx_nxt = 2'h0;
                        ad_nxt  = bus_seq_pkg::NPSA_ADDR;
                    end
                    else
                        idx_nxt = idx_r + 2'h1;
                bus_seq_pkg::CY_NPS:
                    if (idx_r == bus_seq_pkg::FETCH_CNT - 2'h1)
                        cy_nxt = bus_seq_pkg::CY_FETCH;
                    else
                    begin
                        idx_nxt = idx_r + 2'h1;
                        ad_nxt  = ad_r + 16'h0002;
                    end
                default:
                    cy_nxt = bus_seq_pkg::CY_FETCH;
            endcase
            // grant after the cycle's last period
            if (grant_pend_r && req_ok)
                ph_nxt = bus_seq_pkg::PH_GRNT;
        end
        if (ph_r == bus_seq_pkg::PH_T3 && cy_r == bus_seq_pkg::CY_FETCH
            && stop_r)
            cy_nxt = bus_seq_pkg::CY_REFR;
        if (ph_r == bus_seq_pkg::PH_T3 && cy_r == bus_seq_pkg::CY_ACK)
            idx_nxt = 2'h0;
    end

    // bus control outputs for the next phase
    always_comb
    begin
        ctl_nxt               = ctl_r;
        ctl_nxt.addr_strobe_n = ~(ph_nxt == bus_seq_pkg::PH_T1);
        ctl_nxt.data_strobe_n = 1'b1;
        ctl_nxt.mem_req       = 1'b0;
        ctl_nxt.byte_word     = 1'b0;
        if (ph_nxt == bus_seq_pkg::PH_T1)
        begin
            ctl_nxt.read_write = 1'b1;
            ctl_nxt.segment    = bus_seq_pkg::SEG_C;
            unique case (cy_nxt)
                bus_seq_pkg::CY_INIT:
                begin
                    ctl_nxt.status     = bus_seq_pkg::ST_SUB_FETCH;
                    ctl_nxt.normal_sys = 1'b0;
                end
                bus_seq_pkg::CY_FETCH:
                    ctl_nxt.status = bus_seq_pkg::ST_FIRST_FETCH;
                bus_seq_pkg::CY_ACK:
                    ctl_nxt.status = trap_code;
                bus_seq_pkg::CY_PUSH:
                begin
                    ctl_nxt.status     = bus_seq_pkg::ST_STACK;
                    ctl_nxt.normal_sys = 1'b0;
                    ctl_nxt.read_write = 1'b0;
                end
                bus_seq_pkg::CY_NPS:
                begin
                    ctl_nxt.status     = bus_seq_pkg::ST_MEM_OPER;
                    ctl_nxt.normal_sys = 1'b0;
                end
                default:
                    ctl_nxt.status = bus_seq_pkg::ST_REFRESH;
            endcase
        end
        if (ph_nxt != bus_seq_pkg::PH_T1 && ph_nxt != bus_seq_pkg::PH_IDLE
            && cy_nxt != bus_seq_pkg::CY_ACK && cy_nxt != bus_seq_pkg::CY_REFR)
            ctl_nxt.mem_req = 1'b1;
        // data strobe low in T2/waits, and in second ack group
        if ((ph_nxt == bus_seq_pkg::PH_T2 || ph_nxt == bus_seq_pkg::PH_IW
             || ph_nxt == bus_seq_pkg::PH_AW)
            && (cy_nxt != bus_seq_pkg::CY_ACK || idx_nxt == 2'h1))
            ctl_nxt.data_strobe_n = 1'b0;
    end

    // phase, cycle and control registers
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ph_r  <= bus_seq_pkg::PH_RST;
            cy_r  <= bus_seq_pkg::CY_INIT;
            cnt_r <= 2'h0;
            idx_r <= 2'h0;
            ad_r  <= bus_seq_pkg::RST_FLG_ADDR;
            hold_r <= 2'h0;
            // strobes high, status and segment low
            ctl_r <= '{1'b1, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 7'h00};
        end
        else
        begin
            ph_r  <= ph_nxt;
            cy_r  <= cy_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            ad_r  <= ad_nxt;
            hold_r <= (ph_r == bus_seq_pkg::PH_RST) ? hold_r + 2'h1 : 2'h0;
            ctl_r <= ctl_nxt;
        end
    end

    // interrupt latch, grant, stop and resource flags
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nmi_d_r      <= 1'b1;
            nmi_lat_r    <= 1'b1;
            grant_pend_r <= 1'b0;
            grant_r      <= 1'b0;
            stop_r       <= 1'b0;
            atom_r       <= 1'b0;
            ad_oe_r      <= 1'b0;
            id_r         <= 16'h0000;
            ack_code_r   <= 4'h0;
            rr_n_r       <= 1'b1;
            done_r       <= 1'b0;
        end
        else
        begin
            nmi_d_r <= nmi_n;
            // falling edge sets latch; clears at strobe
            if (nmi_fall)
                nmi_lat_r <= 1'b0;
            else if (as_rise && ack_code_r == bus_seq_pkg::ST_NMI_ACK)
                nmi_lat_r <= 1'b1;
            if (in_t1)
                grant_pend_r <= ~bus_request_in_n;
            grant_r <= (ph_nxt == bus_seq_pkg::PH_GRNT);
            if (ph_nxt == bus_seq_pkg::PH_T1 && cy_nxt == bus_seq_pkg::CY_FETCH)
                stop_r <= ~stop_n;
            atom_r <= test_and_set_instruction;
            ad_oe_r <= (ph_nxt == bus_seq_pkg::PH_T1)
                     | (cy_nxt == bus_seq_pkg::CY_PUSH
                        && ph_nxt != bus_seq_pkg::PH_IDLE);
            if (ph_nxt == bus_seq_pkg::PH_T1)
                ack_code_r <= ctl_nxt.status;
            // identifier captured while data strobe low in T3 entry
            if (cy_r == bus_seq_pkg::CY_ACK && ph_nxt == bus_seq_pkg::PH_T3)
                id_r <= muxed_addr_data_in;
            if (!resource_req)
                rr_n_r <= 1'b1;
            else if (resource_busy_n)
                rr_n_r <= 1'b0;
            done_r <= cyc_end && cy_r == bus_seq_pkg::CY_NPS
                      && idx_r == bus_seq_pkg::FETCH_CNT - 2'h1;
        end
    end

    // address/data output word for the next phase
    wire [15:0] ad_sel = (cy_r == bus_seq_pkg::CY_PUSH) ? push_word : ad_r;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            muxed_addr_data_out <= 16'h0000;
        else
            muxed_addr_data_out <= ad_sel;
    end

    assign bus_ctl             = ctl_r;
    assign bus_ctl_oe          = ~grant_r;
    assign muxed_addr_data_oe  = ad_oe_r & ~grant_r;
    assign bus_grant_out_n     = ~grant_r;
    assign resource_req_out_n  = rr_n_r;
    assign refresh_enable      = 1'b0;
    assign ack_identifier      = id_r;
    assign nmi_pending         = ~nmi_lat_r;
    assign fetch_done          = done_r;
endmodule

// ---- tb/bus_seq_sva.sv ----
// checker: port relations of the bus-cycle sequencer
// assumes it is bound to the sequencer, one sys_clk domain
`timescale 1ns/1ps
module bus_seq_sva
(
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    input wire logic                  nmi_n,
    input wire logic                  bus_request_in_n,
    input wire logic                  resource_busy_n,
    input wire logic                  test_and_set_instruction,
    input wire logic                  muxed_addr_data_oe,
    input wire bus_seq_pkg::bus_ctl_t bus_ctl,
    input wire logic                  bus_ctl_oe,
    input wire logic                  bus_grant_out_n,
    input wire logic                  resource_req_out_n,
    input wire logic                  refresh_enable,
    input wire logic                  nmi_pending
);
    logic ack_w;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // an acknowledge cycle is on the bus
    assign ack_w = bus_ctl_oe && bus_ctl.status inside
        {bus_seq_pkg::ST_NMI_ACK, bus_seq_pkg::ST_NVEC_ACK,
         bus_seq_pkg::ST_VEC_ACK, bus_seq_pkg::ST_SEG_ACK};

    reset_idle_a: assert property ($rose(rstn) |->
        bus_ctl.addr_strobe_n && bus_ctl.data_strobe_n && bus_ctl_oe &&
        bus_ctl.status == 4'h0 && bus_ctl.segment == 7'h00 &&
        !muxed_addr_data_oe && bus_grant_out_n && resource_req_out_n)
        else $error("bad output levels after reset");
    refresh_off_a: assert property (!refresh_enable)
        else $error("refresh enabled");
    grant_float_a: assert property (!bus_grant_out_n |->
        !bus_ctl_oe && !muxed_addr_data_oe)
        else $error("bus driven while granted");
    grant_cause_a: assert property ($fell(bus_grant_out_n) |->
        !$past(bus_request_in_n))
        else $error("grant without request");
    grant_free_a: assert property (!bus_grant_out_n &&
        bus_request_in_n |-> ##[1:3] bus_grant_out_n)
        else $error("grant not released");
    atomic_hold_a: assert property (test_and_set_instruction &&
        bus_grant_out_n |=> bus_grant_out_n)
        else $error("grant during atomic instruction");
    ack_wait_a: assert property ($fell(bus_ctl.addr_strobe_n) &&
        ack_w |-> bus_ctl.data_strobe_n [*5])
        else $error("automatic waits cut short");
    strb_two_a: assert property ($fell(bus_ctl.data_strobe_n) &&
        ack_w |-> !bus_ctl.data_strobe_n [*2])
        else $error("data strobe low too briefly");
    nmi_latch_a: assert property ($fell(nmi_n) |->
        ##[0:1] nmi_pending)
        else $error("nmi edge not latched");
    nmi_clear_a: assert property ($rose(bus_ctl.addr_strobe_n) && ack_w
        && bus_ctl.status == bus_seq_pkg::ST_NMI_ACK && nmi_n &&
        $past(nmi_n) |-> ##[0:1] !nmi_pending)
        else $error("nmi latch not cleared");
    res_test_a: assert property ($fell(resource_req_out_n) |->
        $past(resource_busy_n))
        else $error("resource requested while busy");
    stack_sys_a: assert property (bus_ctl_oe &&
        bus_ctl.status == bus_seq_pkg::ST_STACK |-> !bus_ctl.normal_sys)
        else $error("stack push not in system space");
endmodule

bind cpu_bus_cycle_sequencer bus_seq_sva u_sva
(
    .sys_clk, .rstn, .nmi_n, .bus_request_in_n, .resource_busy_n,
    .test_and_set_instruction, .muxed_addr_data_oe, .bus_ctl,
    .bus_ctl_oe, .bus_grant_out_n, .resource_req_out_n,
    .refresh_enable, .nmi_pending
);

// ---- tb/bus_far_side.sv ----
// far side model: memory, interrupting peripheral and wait logic
// assumes registered bus outputs of the sequencer on sys_clk
`timescale 1ns/1ps
module bus_far_side
(
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire bus_seq_pkg::bus_ctl_t bus_ctl,
    input  wire logic                  bus_ctl_oe,
    input  wire logic [15:0]           addr_in,
    input  wire logic [15:0]           ident,
    input  wire logic                  slow,
    output logic      [15:0]           rd_data,
    output logic                       wait_n
);
    logic [15:0] addr_r;
    logic [15:0] last_r;
    logic [15:0] val_w;
    logic [2:0]  cnt_r;
    logic        drv_w;

    // word to return: identifier in acknowledge, else address pattern
    assign drv_w = bus_ctl_oe && !bus_ctl.data_strobe_n;
    assign val_w = bus_ctl.status inside {bus_seq_pkg::ST_NMI_ACK,
        bus_seq_pkg::ST_NVEC_ACK, bus_seq_pkg::ST_VEC_ACK,
        bus_seq_pkg::ST_SEG_ACK} ? ident : addr_r ^ 16'h5A5A;
    // bus shows the inverted last word while strobe is high
    assign rd_data = drv_w ? val_w : ~last_r;
    // slow mode holds wait low while the clock count is three to five
    assign wait_n = !(slow && cnt_r >= 3'h3 && cnt_r <= 3'h5);

    // address latch and clock count since the cycle began
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_r <= 16'h0000;
            last_r <= 16'h0000;
            cnt_r  <= 3'h0;
        end
        else
        begin
            addr_r <= (bus_ctl_oe && !bus_ctl.addr_strobe_n) ? addr_in : addr_r;
            cnt_r  <= (bus_ctl_oe && !bus_ctl.addr_strobe_n) ? 3'h0 :
                      (cnt_r == 3'h7 ? cnt_r : cnt_r + 3'h1);
            last_r <= drv_w ? val_w : last_r;
        end
    end
endmodule

// ---- tb/cpu_bus_cycle_sequencer_test.sv ----
// bench: reset fetch, trap acknowledge, grant, stop, resource
// assumes the far side model and the bound checker
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_test;
    logic                  sys_clk, rstn, stop_n, nmi_n, rq_n, busy_n;
    logic                  rreq, ts_act, slow, wait_n, doe, coe, gnt_n;
    logic                  rout_n, refr, nmi_p, done;
    logic [2:0]            trap_n;
    logic [15:0]           pc, fw_word, ident, rdat, dout, aid;
    bus_seq_pkg::bus_ctl_t ctl;
    int                    fails = 0, n_compared = 0, cyc = 0;

    cpu_bus_cycle_sequencer DUT
    (
        .sys_clk, .rstn, .wait_n, .stop_n, .nmi_n,
        .vectored_interrupt_in(trap_n[0]),
        .nonvectored_interrupt_in(trap_n[1]),
        .segment_trap_in(trap_n[2]), .bus_request_in_n(rq_n),
        .resource_busy_n(busy_n), .resource_req(rreq),
        .last_cycle(1'b1), .test_and_set_instruction(ts_act),
        .pc_value(pc), .flag_control_word(fw_word),
        .muxed_addr_data_in(rdat), .muxed_addr_data_out(dout),
        .muxed_addr_data_oe(doe), .bus_ctl(ctl), .bus_ctl_oe(coe),
        .bus_grant_out_n(gnt_n), .resource_req_out_n(rout_n),
        .refresh_enable(refr), .ack_identifier(aid),
        .nmi_pending(nmi_p), .fetch_done(done)
    );

    bus_far_side far
    (
        .sys_clk, .rstn, .bus_ctl(ctl), .bus_ctl_oe(coe), .addr_in(dout),
        .ident, .slow, .rd_data(rdat), .wait_n
    );

    // clock, and a ceiling on run length
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    // wait for a strobe to fall; return bus word and status
    task automatic fall(input bit dat, output logic [15:0] a,
                        output logic [3:0] s);
        int   k;
        logic p, c;
        p = 1'b0;
        for (k = 0; k < 600; k++)
        begin
            @(negedge sys_clk);
            c = dat ? ctl.data_strobe_n : ctl.addr_strobe_n;
            if (p && !c && coe)
                break;
            p = c;
        end
        chk(16'(k < 600), 16'h0001);
        a = dout;
        s = ctl.status;
    endtask

    task automatic t_reset();
        logic [15:0] a;
        logic [3:0]  s;
        for (int i = 0; i < 3; i++)
        begin
            fall(0, a, s);
            chk(a, bus_seq_pkg::RST_FLG_ADDR + 16'(2 * i));
            chk({s, 4'h0, ctl.normal_sys, ctl.segment},
                {bus_seq_pkg::ST_SUB_FETCH, 5'h00, bus_seq_pkg::SEG_C});
        end
        fall(0, a, s);
        chk(16'(s), 16'(bus_seq_pkg::ST_FIRST_FETCH));
        $display("reset fetch test done");
    endtask

    task automatic t_trap(input int k);
        logic [15:0] a, w[3];
        logic [3:0]  s, code[4];
        code = '{bus_seq_pkg::ST_VEC_ACK, bus_seq_pkg::ST_NVEC_ACK,
                 bus_seq_pkg::ST_SEG_ACK, bus_seq_pkg::ST_NMI_ACK};
        @(posedge sys_clk);
        pc <= 16'h1230 + 16'(k);
        fw_word <= 16'h4000 + 16'(k);
        ident <= 16'hC0D0 + 16'(k);
        slow <= k[0];
        if (k == 3)
            nmi_n <= 1'b0;
        else
            trap_n[k] <= 1'b0;
        @(posedge sys_clk);
        nmi_n <= 1'b1;
        s = 4'h0;
        for (int j = 0; j < 8 && s !== code[k]; j++)
            fall(0, a, s);
        chk(16'(s), 16'(code[k]));
        repeat (2) @(posedge sys_clk);
        trap_n <= 3'h7;
        fall(1, a, s);
        w = '{pc, fw_word, ident};
        for (int j = 0; j < 3; j++)
        begin
            fall(1, a, s);
            chk(a, w[j]);
            chk(16'(s), 16'(bus_seq_pkg::ST_STACK));
        end
        for (int j = 0; j < 3; j++)
        begin
            fall(0, a, s);
            chk(a, bus_seq_pkg::NPSA_ADDR + 16'(2 * j));
        end
        for (int j = 0; j < 50 && done !== 1'b1; j++)
            @(negedge sys_clk);
        chk(16'(done), 16'h0001);
        chk(aid, ident);
        chk(16'(nmi_p), 16'h0000);
        $display("trap test %0d done", k);
    endtask

    task automatic t_grant(input bit atomic);
        int j;
        @(posedge sys_clk);
        ts_act <= atomic;
        repeat (4) @(posedge sys_clk);
        // request held until the transfer ends
        rq_n <= 1'b0;
        for (j = 0; j < 100 && gnt_n !== atomic; j++)
            @(negedge sys_clk);
        repeat (20) @(negedge sys_clk);
        chk(16'({gnt_n, coe, doe & !gnt_n}),
            atomic ? 16'h0006 : 16'h0);
        @(posedge sys_clk);
        rq_n <= 1'b1;
        for (j = 0; j < 10 && gnt_n !== 1'b1; j++)
            @(negedge sys_clk);
        chk(16'(gnt_n), 16'h0001);
        @(posedge sys_clk);
        ts_act <= 1'b0;
        $display("grant test done");
    endtask

    task automatic t_res();
        @(posedge sys_clk);
        busy_n <= 1'b0;
        rreq <= 1'b1;
        repeat (20) @(negedge sys_clk);
        chk(16'(rout_n), 16'h0001);
        @(posedge sys_clk);
        busy_n <= 1'b1;
        for (int j = 0; j < 20 && rout_n !== 1'b0; j++)
            @(negedge sys_clk);
        chk(16'(rout_n), 16'h0000);
        @(posedge sys_clk);
        rreq <= 1'b0;
        $display("resource test done");
    endtask

    task automatic t_stop();
        logic [15:0] a;
        logic [3:0]  s;
        @(posedge sys_clk);
        rstn <= 1'b0;
        stop_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int j = 0; j < 6; j++)
            fall(0, a, s);
        chk(16'(s), 16'(bus_seq_pkg::ST_REFRESH));
        chk(16'(refr), 16'h0000);
        @(posedge sys_clk);
        stop_n <= 1'b1;
        fall(0, a, s);
        fall(0, a, s);
        chk(16'(s == bus_seq_pkg::ST_REFRESH), 16'h0000);
        $display("stop test done");
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {rstn, rreq, ts_act, slow} = 4'h0;
        {stop_n, nmi_n, rq_n, busy_n, trap_n} = 7'h7F;
        {pc, fw_word, ident} = 48'h0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        for (int k = 0; k < 4; k++)
            t_trap(k);
        t_grant(1'b0);
        t_grant(1'b1);
        t_res();
        t_stop();
        summarize();
    end
endmodule
